/* File: rtl/msb_sideband.sv */
// sideband control pins: select gating, reset sequence, low power, presence, attention
//
// Summary of operation
// R1 - select low: pass management bus traffic
// R2 - select high: block all management traffic
// R3 - undriven select input reads as deselected
// R4 - long enough reset low resets user settings
// R5 - init interval starts at reset rising edge
// R6 - host ignores status until reset completes
// R7 - reset end raises attention, not-ready cleared
// R8 - power-up posts same completion attention
// R9 - low power request enters reduced power
// R10 - presence output tied low internally
// R11 - attention driven low on fault/critical status
// R12 - host reads status to find cause
// R13 - host reads flag field for channel/type
// R14 - release attention once flags read, none pending
`timescale 1ns/1ps
`default_nettype none
module msb_sideband #(
  parameter int INIT_CYCLES = msb_pkg::INIT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  // host pins
  input wire logic module_select_n,
  input wire logic module_select_hiz,
  input wire logic module_reset_n,
  input wire logic module_reset_hiz,
  input wire logic low_power_request,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic module_present_n_o,
  output logic module_present_n_oe_n,
  output logic attention_n_o,
  output logic attention_n_oe_n,
  // internal management slave side
  output logic mgmt_scl,
  output logic mgmt_sda,
  input wire logic mgmt_sda_oe_n,
  output logic mgmt_selected,
  // internal status and control
  input wire logic [msb_pkg::FLAG_W-1:0] fault_event,
  input wire logic [msb_pkg::FLAG_W-1:0] flag_mask,
  input wire logic flag_read,
  input wire logic status_read,
  output logic user_settings_reset_n,
  output logic low_power_en,
  output msb_pkg::msb_status_type status
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [msb_pkg::PIN_W-1:0] pin_raw;
  logic [msb_pkg::PIN_W-1:0] pin_s;
  logic sel_n_s;
  logic rst_pin_s;
  logic lpm_s;
  logic scl_s;
  logic sda_s;

  always_comb
  begin
    pin_raw = '0;
    pin_raw[msb_pkg::PIN_SEL] = module_select_hiz | module_select_n; // R3
    pin_raw[msb_pkg::PIN_RST] = module_reset_hiz | module_reset_n;
    pin_raw[msb_pkg::PIN_LPM] = low_power_request;
    pin_raw[msb_pkg::PIN_SCL] = scl_i;
    pin_raw[msb_pkg::PIN_SDA] = sda_i;
  end

  msb_sync2 #(
    .W(msb_pkg::PIN_W),
    .INIT(msb_pkg::PIN_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign sel_n_s = pin_s[msb_pkg::PIN_SEL];
  assign rst_pin_s = pin_s[msb_pkg::PIN_RST];
  assign lpm_s = pin_s[msb_pkg::PIN_LPM];
  assign scl_s = pin_s[msb_pkg::PIN_SCL];
  assign sda_s = pin_s[msb_pkg::PIN_SDA];

  // ----------------------------------------------------------------
  // management bus gating
  // ----------------------------------------------------------------
  logic scl_r;
  logic scl_nxt;
  logic sda_r;
  logic sda_nxt;
  logic sel_r;
  logic sel_nxt;
  logic sda_oe_n_r;
  logic sda_oe_n_nxt;

  always_comb
  begin
    sel_nxt = ~sel_n_s;
    if (!sel_n_s)
    begin
      scl_nxt = scl_s; // R1
      sda_nxt = sda_s; // R1
      sda_oe_n_nxt = mgmt_sda_oe_n; // R1
    end
    else
    begin
      scl_nxt = 1'b1; // R2
      sda_nxt = 1'b1; // R2
      sda_oe_n_nxt = 1'b1; // R2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      sel_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else
    begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      sel_r <= sel_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
    end
  end

  assign mgmt_scl = scl_r;
  assign mgmt_sda = sda_r;
  assign mgmt_selected = sel_r;
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_r;

  // ----------------------------------------------------------------
  // reset and initialisation sequence
  // ----------------------------------------------------------------
  localparam logic [msb_pkg::RST_CNT_W-1:0] RST_MIN =
    msb_pkg::RST_CNT_W'(msb_pkg::RESET_MIN_CYCLES);
  localparam logic [msb_pkg::INIT_CNT_W-1:0] INIT_LAST =
    msb_pkg::INIT_CNT_W'(INIT_CYCLES - 1);

  msb_pkg::msb_state_type state_r;
  msb_pkg::msb_state_type state_nxt;
  logic [msb_pkg::RST_CNT_W-1:0] rst_cnt_r;
  logic [msb_pkg::RST_CNT_W-1:0] rst_cnt_nxt;
  logic [msb_pkg::INIT_CNT_W-1:0] init_cnt_r;
  logic [msb_pkg::INIT_CNT_W-1:0] init_cnt_nxt;
  logic user_rst_n_r;
  logic user_rst_n_nxt;
  logic dnr_r;
  logic dnr_nxt;
  logic init_done;

  always_comb
  begin
    state_nxt = state_r;
    rst_cnt_nxt = rst_cnt_r;
    init_cnt_nxt = init_cnt_r;
    user_rst_n_nxt = user_rst_n_r;
    dnr_nxt = dnr_r;
    init_done = 1'b0;
    unique case (state_r)
      msb_pkg::ST_INIT:
      begin
        user_rst_n_nxt = 1'b0;
        dnr_nxt = 1'b1;
        if (!rst_pin_s)
        begin
          state_nxt = msb_pkg::ST_RESET_LOW;
          rst_cnt_nxt = msb_pkg::RST_CNT_ONE;
          init_cnt_nxt = msb_pkg::INIT_CNT_ZERO;
        end
        else if (init_cnt_r == INIT_LAST)
        begin
          state_nxt = msb_pkg::ST_RUN;
          init_done = 1'b1; // R7 R8
          user_rst_n_nxt = 1'b1;
          dnr_nxt = 1'b0; // R7
          init_cnt_nxt = msb_pkg::INIT_CNT_ZERO;
        end
        else
        begin
          init_cnt_nxt = init_cnt_r + msb_pkg::INIT_CNT_ONE;
        end
      end
      msb_pkg::ST_RUN:
      begin
        if (!rst_pin_s)
        begin
          state_nxt = msb_pkg::ST_RESET_LOW;
          rst_cnt_nxt = msb_pkg::RST_CNT_ONE;
        end
      end
      msb_pkg::ST_RESET_LOW:
      begin
        if (rst_pin_s)
        begin
          rst_cnt_nxt = msb_pkg::RST_CNT_ZERO;
          if (rst_cnt_r > RST_MIN)
          begin
            state_nxt = msb_pkg::ST_INIT; // R5
            init_cnt_nxt = msb_pkg::INIT_CNT_ZERO; // R5
          end
          else if (dnr_r)
          begin
            state_nxt = msb_pkg::ST_INIT;
          end
          else
          begin
            state_nxt = msb_pkg::ST_RUN;
          end
        end
        else
        begin
          if (rst_cnt_r <= RST_MIN)
          begin
            rst_cnt_nxt = rst_cnt_r + msb_pkg::RST_CNT_ONE;
          end
          if (rst_cnt_r > RST_MIN)
          begin
            user_rst_n_nxt = 1'b0; // R4
            dnr_nxt = 1'b1; // R4
          end
        end
      end
      default:
      begin
        state_nxt = msb_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= msb_pkg::ST_INIT; // R8
      rst_cnt_r <= msb_pkg::RST_CNT_ZERO;
      init_cnt_r <= msb_pkg::INIT_CNT_ZERO;
      user_rst_n_r <= 1'b0;
      dnr_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      init_cnt_r <= init_cnt_nxt;
      user_rst_n_r <= user_rst_n_nxt;
      dnr_r <= dnr_nxt;
    end
  end

  assign user_settings_reset_n = user_rst_n_r;

  // ----------------------------------------------------------------
  // latched flags and attention output
  // ----------------------------------------------------------------
  logic [msb_pkg::FLAG_W-1:0] flags_r;
  logic [msb_pkg::FLAG_W-1:0] flags_nxt;
  logic done_r;
  logic done_nxt;
  logic att_r;
  logic att_nxt;
  logic lp_r;
  logic lp_nxt;

  always_comb
  begin
    flags_nxt = flags_r;
    done_nxt = done_r;
    if (!user_rst_n_r)
    begin
      flags_nxt = msb_pkg::FLAG_NONE;
    end
    else
    begin
      if (flag_read)
      begin
        flags_nxt = msb_pkg::FLAG_NONE; // R14
      end
      flags_nxt = flags_nxt | fault_event;
    end
    if (status_read)
    begin
      done_nxt = 1'b0; // R14
    end
    if (init_done)
    begin
      done_nxt = 1'b1; // R7 R8
    end
    else if (dnr_r)
    begin
      done_nxt = 1'b0;
    end
    att_nxt = ~dnr_nxt & (done_nxt | (|(flags_nxt & ~flag_mask))); // R11 R14
    lp_nxt = lpm_s; // R9
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_r <= msb_pkg::FLAG_NONE;
      done_r <= 1'b0;
      att_r <= 1'b0;
      lp_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      done_r <= done_nxt;
      att_r <= att_nxt;
      lp_r <= lp_nxt;
    end
  end

  assign attention_n_o = 1'b0;
  assign attention_n_oe_n = ~att_r; // R11
  assign module_present_n_o = 1'b0; // R10
  assign module_present_n_oe_n = 1'b0; // R10
  assign low_power_en = lp_r; // R9

  always_comb
  begin
    status.data_not_ready = dnr_r;
    status.reset_done = done_r;
    status.low_power = lp_r;
    status.flags = flags_r; // R12 R13
  end

endmodule
`default_nettype wire

/* File: rtl/msb_pkg.sv */
// shared constants and types for the module sideband control block
`default_nettype none
package msb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int RESET_MIN_US = 10;
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * CLK_MHZ;
  localparam int INIT_MS = 2000;
  localparam int INIT_CYCLES = INIT_MS * 1000 * CLK_MHZ;
  localparam int LOW_POWER_LIMIT_MW = 1000;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_W = 8;
  localparam int RST_CNT_W = 16;
  localparam int INIT_CNT_W = 32;
  localparam int PIN_W = 5;
  localparam int PIN_SEL = 0;
  localparam int PIN_RST = 1;
  localparam int PIN_LPM = 2;
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 4;
  localparam logic [PIN_W-1:0] PIN_IDLE = 5'h1B;
  localparam logic [FLAG_W-1:0] FLAG_NONE = 8'h00;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 16'h0000;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ONE = 16'h0001;
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_ZERO = 32'h00000000;
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_ONE = 32'h00000001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_RESET_LOW
  } msb_state_type;

  typedef struct packed {
    logic data_not_ready;
    logic reset_done;
    logic low_power;
    logic [FLAG_W-1:0] flags;
  } msb_status_type;

endpackage
`default_nettype wire

/* File: rtl/msb_sync2.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module msb_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

/* File: testbench/msb_host.sv */
// host board model: drives the select and reset pins and pulls up the open-drain wires
`timescale 1ns/1ps
`default_nettype none
module msb_host
(
  input wire logic sel_req,
  input wire logic sel_float,
  input wire logic rst_req,
  input wire logic sda_oe_n,
  input wire logic attention_n_oe_n,
  input wire logic module_present_n_oe_n,
  input wire logic sda_o,
  input wire logic attention_n_o,
  input wire logic module_present_n_o,
  output logic module_select_n,
  output logic module_select_hiz,
  output logic module_reset_n,
  output logic sda_i,
  output logic attention_pin,
  output logic present_pin
);
  // a released select line shows the wrong level; only the module pull-up makes it high
  assign module_select_hiz = sel_float;
  assign module_select_n = ~(sel_req | sel_float);
  assign module_reset_n = ~rst_req;
  // open-drain wires read high unless driven by the module
  assign sda_i = sda_oe_n ? 1'b1 : sda_o;
  assign attention_pin = attention_n_oe_n ? 1'b1 : attention_n_o;
  assign present_pin = module_present_n_oe_n ? 1'b1 : module_present_n_o;
endmodule
`default_nettype wire

/* File: testbench/msb_sideband_monitor.sv */
// assertion checker for the sideband control block
`timescale 1ns/1ps
`default_nettype none
module msb_monitor #(
  parameter int INIT_CYCLES = 20
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic module_select_n,
  input wire logic module_select_hiz,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic [msb_pkg::FLAG_W-1:0] fault_event,
  input wire logic [msb_pkg::FLAG_W-1:0] flag_mask,
  input wire logic flag_read,
  input wire logic sda_oe_n,
  input wire logic attention_n_oe_n,
  input wire logic mgmt_scl,
  input wire logic mgmt_selected,
  input wire logic user_settings_reset_n,
  input wire logic low_power_en,
  input wire msb_pkg::msb_status_type status
);
  localparam int INIT_HI = INIT_CYCLES + 12;
  logic [9:0] rlow_r;
  logic [9:0] rlow_nxt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // cycles the reset pin has been low
  always_comb
  begin
    rlow_nxt = module_reset_n ? 10'h000 : rlow_r + 10'h001;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rlow_r <= 10'h000;
    else
      rlow_r <= rlow_nxt;
  end
  property p_sel;
    (!module_select_n && !module_select_hiz)[*4] |-> mgmt_selected;
  endproperty
  a_sel: assert property (p_sel) else $error("select not passed");
  property p_desel;
    (module_select_n || module_select_hiz)[*4] |-> !mgmt_selected && mgmt_scl && sda_oe_n;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect leaks");
  property p_rst;
    rlow_r == 10'h104 |-> !user_settings_reset_n && status.data_not_ready;
  endproperty
  a_rst: assert property (p_rst) else $error("long reset ignored");
  property p_init;
    rlow_r > 10'h104 && module_reset_n
      |-> status.data_not_ready[*8] ##[1:INIT_HI] status.reset_done;
  endproperty
  a_init: assert property (p_init) else $error("init interval wrong");
  property p_done;
    $rose(status.reset_done) |-> !status.data_not_ready && !attention_n_oe_n;
  endproperty
  a_done: assert property (p_done) else $error("done without attention");
  property p_lpm;
    low_power_request[*4] |-> low_power_en && status.low_power;
  endproperty
  a_lpm: assert property (p_lpm) else $error("low power missed");
  property p_att;
    |(fault_event & ~flag_mask) && !status.data_not_ready |=> !attention_n_oe_n;
  endproperty
  a_att: assert property (p_att) else $error("attention missed");
  property p_rel;
    flag_read && !status.reset_done && !status.data_not_ready && fault_event == 8'h00
      |=> attention_n_oe_n && status.flags == 8'h00;
  endproperty
  a_rel: assert property (p_rel) else $error("attention not released");
  c_att: cover property (!attention_n_oe_n ##1 attention_n_oe_n);
  c_lpm: cover property (low_power_en);
  c_usr: cover property (!user_settings_reset_n);
endmodule
bind msb_sideband msb_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_msb_monitor (
  .core_clk, .rst_n, .module_select_n, .module_select_hiz, .module_reset_n,
  .low_power_request, .fault_event, .flag_mask, .flag_read, .sda_oe_n,
  .attention_n_oe_n, .mgmt_scl, .mgmt_selected, .user_settings_reset_n,
  .low_power_en, .status
);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst_n, module_select_n, module_select_hiz, module_reset_n;
  logic low_power_request, scl_i, sda_i, sda_oe_n, mgmt_scl, mgmt_sda_oe_n;
  logic mgmt_selected, flag_read, status_read, user_settings_reset_n, low_power_en;
  logic attention_n_oe_n, module_present_n_oe_n, sel_req, sel_float, rst_req;
  logic att_pin, pres_pin;
  logic sda_o, module_present_n_o, attention_n_o, mgmt_sda;
  logic [msb_pkg::FLAG_W-1:0] fault_event, flag_mask;
  msb_pkg::msb_status_type status;
  int errors, cmp_count, cyc;
  msb_sideband #(.INIT_CYCLES(20)) u_msb_sideband (
    .core_clk, .rst_n, .module_select_n, .module_select_hiz, .module_reset_n,
    .module_reset_hiz(1'h0), .low_power_request, .scl_i, .sda_i, .sda_o,
    .sda_oe_n, .module_present_n_o, .module_present_n_oe_n, .attention_n_o,
    .attention_n_oe_n, .mgmt_scl, .mgmt_sda, .mgmt_sda_oe_n, .mgmt_selected,
    .fault_event, .flag_mask, .flag_read, .status_read, .user_settings_reset_n,
    .low_power_en, .status
  );
  msb_host u_msb_host (
    .sel_req, .sel_float, .rst_req, .sda_oe_n, .attention_n_oe_n,
    .module_present_n_oe_n, .sda_o, .attention_n_o, .module_present_n_o,
    .module_select_n, .module_select_hiz, .module_reset_n,
    .sda_i, .attention_pin(att_pin), .present_pin(pres_pin)
  );
  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_done();
    for (int n = 0; n < 60 && status.reset_done !== 1'h1; n++)
      tick(1);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'h0;
    {sel_req, sel_float, rst_req, low_power_request, flag_read, status_read} = 6'h00;
    scl_i = 1'h1;
    mgmt_sda_oe_n = 1'h1;
    fault_event = 8'h00;
    flag_mask = 8'h00;
    tick(6);
    rst_n = 1'h1;
    wait_done();
    chk("not_ready", 8'(status.data_not_ready), 8'h00);
    chk("attention", 8'(att_pin), 8'h00);
    chk("present", 8'(pres_pin), 8'h00);
    pulse(status_read);
    tick(1);
    chk("attention", 8'(att_pin), 8'h01);
    $display("power-up test done");
    sel_req = 1'h1;
    scl_i = 1'h0;
    mgmt_sda_oe_n = 1'h0;
    tick(6);
    chk("select", 8'({mgmt_selected, mgmt_scl, sda_i, mgmt_sda}), 8'h08);
    sel_req = 1'h0;
    tick(5);
    chk("deselect", 8'({mgmt_selected, mgmt_scl, sda_i, mgmt_sda}), 8'h07);
    sel_req = 1'h1;
    sel_float = 1'h1;
    tick(5);
    chk("float", 8'(mgmt_selected), 8'h00);
    sel_float = 1'h0;
    mgmt_sda_oe_n = 1'h1;
    low_power_request = 1'h1;
    tick(4);
    chk("low_power", 8'({low_power_en, status.low_power}), 8'h03);
    low_power_request = 1'h0;
    $display("pin test done");
    for (int i = 0; i < 9; i++)
    begin
      flag_mask = (i == 8) ? 8'hFF : 8'h00;
      fault_event = 8'h01 << (i % 8);
      tick(1);
      fault_event = 8'h00;
      chk("flags", status.flags, 8'h01 << (i % 8));
      chk("attention", 8'(att_pin), 8'((i == 8) ? 1 : 0));
      pulse(flag_read);
      chk("cleared", 8'({status.flags != 8'h00, att_pin}), 8'h01);
    end
    flag_mask = 8'h00;
    $display("flag test done");
    rst_req = 1'h1;
    tick(100);
    rst_req = 1'h0;
    tick(5);
    chk("short_reset", 8'(user_settings_reset_n), 8'h01);
    rst_req = 1'h1;
    tick(300);
    chk("long_reset", 8'({user_settings_reset_n, status.data_not_ready}), 8'h01);
    rst_req = 1'h0;
    tick(8);
    chk("init", 8'(status.data_not_ready), 8'h01);
    wait_done();
    chk("done", 8'({status.data_not_ready, att_pin}), 8'h00);
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
